/* File: src/shp_pkg.sv */
// Function
// - report every bin sort result on the nine category lines, reject and aux lines
// - flag primary above limit when primary exceeds the high limits of bins one to nine
// - flag primary below limit when primary is under the low limits of bins one to nine
// - flag secondary fail when secondary lies outside its high/low window
// - in pin trigger mode start a measurement on a rising trigger line edge seen in idle or publish
// - while panel lock is asserted ignore front-panel keys, resume when released
// - assert the contact alarm while the measurement circuit is interrupted
// - assert analog done when the analog phase ends so parts may be exchanged
// - sort outputs count as valid only once measurement complete is asserted
// - assert measurement complete only when data and sort outputs are valid
// - in list sweep mode the sort lines and the secondary flag carry list pass/fail meaning; the primary flags stay inactive
// - every handler output is active low
package shp_pkg;

  // clock and trigger pulse timing
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned TRIG_MIN_NS    = 1000;
  localparam int unsigned TRIG_MIN_CYC   = (TRIG_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // sizes of the sorting port and depth of the input synchronisers
  localparam int unsigned NUM_BINS       = 9;
  localparam int unsigned NUM_LIST_PTS   = 10;
  localparam int unsigned SYNC_STAGES    = 3;

  // reset values, all handler lines inactive (high)
  localparam logic        LINE_IDLE_N    = 1'h1;
  localparam logic [8:0]  CAT_IDLE_N     = 9'h1ff;

  // active-low sorting word as driven onto the handler pins
  typedef struct packed {
    logic [8:0] sort_category_lines;
    logic       reject;
    logic       aux;
    logic       primary_above_limit;
    logic       primary_below_limit;
    logic       secondary_fail;
  } shp_sort_t;

  localparam shp_sort_t SORT_IDLE_N = '{
    sort_category_lines : CAT_IDLE_N,
    reject              : LINE_IDLE_N,
    aux                 : LINE_IDLE_N,
    primary_above_limit : LINE_IDLE_N,
    primary_below_limit : LINE_IDLE_N,
    secondary_fail      : LINE_IDLE_N
  };

  // measurement sequence
  typedef enum logic [1:0] {
    SHP_IDLE,
    SHP_ANALOG,
    SHP_COMPARE,
    SHP_PUBLISH
  } shp_state_t;

endpackage : shp_pkg

/* File: src/shp_handler_port.sv */
`timescale 1ns/1ps
module shp_handler_port #(
  parameter int unsigned VAL_W = 24,
  parameter int unsigned NKEYS = 8
) (
  // clock and reset
  input  wire  logic                              clock,
  input  wire  logic                              rst_n,
  // handler input pins, asynchronous
  input  wire  logic                              trigger_in_line,
  input  wire  logic                              key_lock_n,
  // handler output pins, active low
  output shp_pkg::shp_sort_t                      sort_n_q,
  output logic                                    analog_done_n_q,
  output logic                                    measurement_complete_n_q,
  output logic                                    contact_alarm_n_q,
  // instrument configuration
  input  wire  logic                              pin_trigger_mode,
  input  wire  logic                              list_mode,
  input  wire  logic                              aux_enable,
  input  wire  logic                              soft_trigger,
  // measurement engine
  input  wire  logic                              analog_done_evt,
  input  wire  logic                              result_evt,
  input  wire  logic                              contact_open,
  input  wire  logic [VAL_W-1:0]                  primary_val,
  input  wire  logic [VAL_W-1:0]                  secondary_val,
  input  wire  logic [shp_pkg::NUM_BINS*VAL_W-1:0] bin_hi,
  input  wire  logic [shp_pkg::NUM_BINS*VAL_W-1:0] bin_lo,
  input  wire  logic [VAL_W-1:0]                  sec_hi,
  input  wire  logic [VAL_W-1:0]                  sec_lo,
  input  wire  logic [shp_pkg::NUM_LIST_PTS-1:0]  list_fail,
  output logic                                    meas_start_q,
  output logic                                    busy_q,
  // front panel keys
  input  wire  logic [NKEYS-1:0]                  key_press,
  output logic [NKEYS-1:0]                        key_accept_q
);

  localparam int unsigned NB = shp_pkg::NUM_BINS;
  localparam int unsigned NS = shp_pkg::SYNC_STAGES;

  // overview of the handler side, in the order a part moves through it:
  //
  // start sources
  // - pin mode: the trigger line is an outside signal with no timing
  //   relation to our clock, so it passes three flops first
  // - a level only counts once stages two and three agree, which filters
  //   single-cycle noise on a long cable at the cost of one cycle latency
  // - the rising edge is taken from that filtered level, never from the
  //   raw pin, so one clean pulse gives exactly one start
  // - soft mode: the engine's own request is already on our clock and is
  //   used as is; in pin mode it is ignored and the other way round
  //
  // sequence
  // - idle, analog, compare, publish; publish lasts a single cycle
  // - a start is only taken in idle or publish, so a handler that fires
  //   early while a part is still under test gets no second start
  // - a refused start leaves no trace; the handler sees it only as a
  //   missing drop of the done lines
  //
  // outputs towards the handler
  // - all lines are low when asserted and high at reset; done and complete stay low through idle until the next start
  // - analog done goes low as soon as the terminals may be released, so
  //   the handler can swap the part while the compare is still running
  // - the sort word is loaded in the compare cycle that sees the result,
  //   and complete follows one cycle later; the handler therefore never
  //   samples a word that is still settling
  // - a new start raises analog done and complete again but leaves the
  //   old sort word on the pins until the next result replaces it
  //
  // limitations
  // - bin windows are compared as unsigned values
  // - where windows overlap the lowest numbered bin is reported
  // - above and below flags are raised only when the value lies beyond
  //   every one of the nine limits, not beyond the matched bin alone
  // - the contact alarm is a plain registered copy of the detector; any
  //   debounce belongs to the engine that drives it

  // synchroniser chains and filtered levels
  logic [NS-1:0]       trg_sync_q;
  logic [NS-1:0]       lock_sync_q;
  logic                trg_lvl_q;
  logic                lock_lvl_q;
  wire                 trg_agree;
  wire                 lock_agree;
  wire                 trg_rise;
  wire                 panel_locked;

  // sequencing
  shp_pkg::shp_state_t state_q;
  shp_pkg::shp_state_t state_d;
  wire                 start_req;
  wire                 start_ok;

  // comparator
  logic [NB-1:0]       in_bin;
  logic [NB-1:0]       over_hi;
  logic [NB-1:0]       under_lo;
  wire  [NB-1:0]       first_bin;
  wire                 any_bin;
  wire                 above_all;
  wire                 below_all;
  wire                 sec_bad;
  shp_pkg::shp_sort_t  bin_sort;
  shp_pkg::shp_sort_t  list_sort;
  shp_pkg::shp_sort_t  next_sort;

  // three-stage synchronisers; stage one feeds stage two only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trg_sync_q  <= '0;
      lock_sync_q <= '1;
    end else begin
      trg_sync_q  <= {trg_sync_q[NS-2:0], trigger_in_line};
      lock_sync_q <= {lock_sync_q[NS-2:0], key_lock_n};
    end
  end

  // a level change counts only once stages two and three agree
  assign trg_agree  = (trg_sync_q[1] == trg_sync_q[2]);
  assign lock_agree = (lock_sync_q[1] == lock_sync_q[2]);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trg_lvl_q  <= 1'h0;
      lock_lvl_q <= 1'h1;
    end else begin
      if (trg_agree) trg_lvl_q <= trg_sync_q[2];
      if (lock_agree) lock_lvl_q <= lock_sync_q[2];
    end
  end

  // edge taken after filtering, so a glitch shorter than two cycles is lost
  assign trg_rise     = trg_agree & trg_sync_q[2] & ~trg_lvl_q;
  assign panel_locked = ~lock_lvl_q;

  // front panel key gate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_accept_q <= '0;
    end else begin
      key_accept_q <= panel_locked ? '0 : key_press;
    end
  end

  // start source follows the trigger mode; the pin is ignored otherwise
  assign start_req = pin_trigger_mode ? trg_rise : soft_trigger;
  // a start during a running measurement is dropped, not queued
  assign start_ok  = start_req & ((state_q == shp_pkg::SHP_IDLE) |
                                  (state_q == shp_pkg::SHP_PUBLISH));

  // next state of the measurement sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      shp_pkg::SHP_IDLE: begin
        if (start_ok) state_d = shp_pkg::SHP_ANALOG;
      end
      shp_pkg::SHP_ANALOG: begin
        if (analog_done_evt) state_d = shp_pkg::SHP_COMPARE;
      end
      shp_pkg::SHP_COMPARE: begin
        if (result_evt) state_d = shp_pkg::SHP_PUBLISH;
      end
      shp_pkg::SHP_PUBLISH: begin
        state_d = start_ok ? shp_pkg::SHP_ANALOG : shp_pkg::SHP_IDLE;
      end
      default: begin
        state_d = shp_pkg::SHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) state_q <= shp_pkg::SHP_IDLE;
    else        state_q <= state_d;
  end

  // per-bin window compare
  // each bin gets its own pair of comparators; with nine bins of full
  // width this is the largest piece of the block, traded for a result
  // that is ready in the same cycle the engine flags it
  // a bin whose low limit lies above its high limit never matches
  genvar gb;
  generate
    for (gb = 0; gb < NB; gb++) begin : g_bin
      wire [VAL_W-1:0] hi = bin_hi[gb*VAL_W +: VAL_W];
      wire [VAL_W-1:0] lo = bin_lo[gb*VAL_W +: VAL_W];
      assign over_hi[gb]  = (primary_val > hi);
      assign under_lo[gb] = (primary_val < lo);
      assign in_bin[gb]   = ~over_hi[gb] & ~under_lo[gb];
    end
  endgenerate

  // lowest numbered bin wins when windows overlap
  // subtracting one clears the lowest set bit and sets all below it, so
  // the masked value keeps only that lowest bit
  assign first_bin = in_bin & ~(in_bin - NB'(1));
  assign any_bin   = |in_bin;
  assign above_all = &over_hi;
  assign below_all = &under_lo;
  assign sec_bad   = (secondary_val > sec_hi) | (secondary_val < sec_lo);

  // bin comparison word, active low; a good primary with a bad secondary
  // goes to aux when enabled, otherwise to reject
  always_comb begin
    bin_sort.sort_category_lines = ~((sec_bad) ? '0 : first_bin);
    bin_sort.reject              = ~(~any_bin | (sec_bad & ~aux_enable));
    bin_sort.aux                 = ~(any_bin & sec_bad & aux_enable);
    bin_sort.primary_above_limit = ~above_all;
    bin_sort.primary_below_limit = ~below_all;
    bin_sort.secondary_fail      = ~sec_bad;
  end

  // list sweep word: each line is a point's out-of-limit flag
  // point ten uses the reject line, aux and secondary carry the overall
  // verdict, and the primary flags have no meaning so they stay inactive
  always_comb begin
    list_sort.sort_category_lines = ~list_fail[NB-1:0];
    list_sort.reject              = ~list_fail[NB];
    list_sort.aux                 = ~(|list_fail);
    list_sort.primary_above_limit = shp_pkg::LINE_IDLE_N;
    list_sort.primary_below_limit = shp_pkg::LINE_IDLE_N;
    list_sort.secondary_fail      = ~(|list_fail);
  end

  assign next_sort = list_mode ? list_sort : bin_sort;

  // sort outputs change only when a result lands; a new start keeps the
  // old word so the handler never sees a half-built result
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sort_n_q <= shp_pkg::SORT_IDLE_N;
    end else if ((state_q == shp_pkg::SHP_COMPARE) && result_evt) begin
      sort_n_q <= next_sort;
    end
  end

  // analog done: dropped on start, asserted when the analog phase ends
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      analog_done_n_q <= shp_pkg::LINE_IDLE_N;
    end else if (start_ok) begin
      analog_done_n_q <= shp_pkg::LINE_IDLE_N;
    end else if ((state_q == shp_pkg::SHP_ANALOG) && analog_done_evt) begin
      analog_done_n_q <= 1'h0;
    end
  end

  // complete goes low one cycle after the sort word is loaded, so the
  // word is already stable when the handler samples it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      measurement_complete_n_q <= shp_pkg::LINE_IDLE_N;
    end else if (start_ok) begin
      measurement_complete_n_q <= shp_pkg::LINE_IDLE_N;
    end else if (state_q == shp_pkg::SHP_PUBLISH) begin
      measurement_complete_n_q <= 1'h0;
    end
  end

  // contact alarm follows the open-circuit detector
  // it is independent of the sequence, so a contact lost between parts
  // is shown to the handler at once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) contact_alarm_n_q <= shp_pkg::LINE_IDLE_N;
    else        contact_alarm_n_q <= ~contact_open;
  end

  // engine handshake
  // busy is taken from the next state so it rises together with the start
  // pulse and falls when the sort word is loaded, one cycle before complete
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meas_start_q <= 1'h0;
      busy_q       <= 1'h0;
    end else begin
      meas_start_q <= start_ok;
      busy_q       <= (state_d == shp_pkg::SHP_ANALOG) | (state_d == shp_pkg::SHP_COMPARE);
    end
  end

endmodule : shp_handler_port

/* File: sim/shp_handler_port_properties.sv */
`timescale 1ns/1ps
module shp_handler_port_properties #(
  parameter int unsigned NKEYS = 8
) (
  // clock and reset
  input wire logic               clock,
  input wire logic               rst_n,
  // pins and engine inputs
  input wire logic               trigger_in_line,
  input wire logic               key_lock_n,
  input wire logic               pin_trigger_mode,
  input wire logic               list_mode,
  input wire logic               analog_done_evt,
  input wire logic               result_evt,
  input wire logic               contact_open,
  input wire logic [NKEYS-1:0]   key_press,
  // outputs under watch
  input wire shp_pkg::shp_sort_t sort_n_q,
  input wire logic               analog_done_n_q,
  input wire logic               measurement_complete_n_q,
  input wire logic               contact_alarm_n_q,
  input wire logic               meas_start_q,
  input wire logic [NKEYS-1:0]   key_accept_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // sequencing of start, analog done and completion, and the sort word
  a_start_one_cycle: assert property (meas_start_q |=> !meas_start_q) else $error("start too long");
  a_start_clears: assert property (meas_start_q |-> analog_done_n_q && measurement_complete_n_q)
    else $error("start left done low");
  a_pin_edge_start: assert property (meas_start_q && pin_trigger_mode |-> $past(trigger_in_line, 2))
    else $error("pin start without edge");
  a_done_cause: assert property ($fell(analog_done_n_q) |-> $past(analog_done_evt))
    else $error("analog done without event");
  a_complete_cause: assert property ($fell(measurement_complete_n_q) |-> $past(result_evt, 2) && !analog_done_n_q)
    else $error("complete without result");
  a_sort_held: assert property (!measurement_complete_n_q |-> $stable(sort_n_q))
    else $error("sort moved while complete");
  a_sort_cause: assert property ($changed(sort_n_q) |-> $past(result_evt))
    else $error("sort moved without result");
  a_one_bin: assert property (!measurement_complete_n_q && !list_mode |-> $onehot0(~sort_n_q.sort_category_lines))
    else $error("two bins asserted");
  // alarm and panel lock
  a_alarm_follow: assert property (contact_open |=> !contact_alarm_n_q)
    else $error("alarm missed");
  a_lock_blocks: assert property (!key_lock_n [*6] |-> key_accept_q == '0)
    else $error("key taken while locked");
  a_keys_pass: assert property (key_lock_n [*6] |-> key_accept_q == $past(key_press))
    else $error("key lost while unlocked");
  // main scenarios reached
  c_list: cover property (!measurement_complete_n_q && list_mode);
  c_pin: cover property (meas_start_q && pin_trigger_mode);
  c_alarm: cover property (!contact_alarm_n_q);
endmodule : shp_handler_port_properties

/* File: sim/shp_handler_model.sv */
`timescale 1ns/1ps
module shp_handler_model (
  // clock and request from the bench
  input wire logic clock,
  input wire logic go,
  // handler trigger pin
  output logic     trigger_in_line
);
  // one pulse per request, held the minimum width; the pin idles low between pulses
  initial trigger_in_line = 1'h0;
  always @(posedge clock) begin
    if (go) begin
      trigger_in_line <= 1'h1;
      repeat (shp_pkg::TRIG_MIN_CYC) @(posedge clock);
      trigger_in_line <= 1'h0;
    end
  end
endmodule : shp_handler_model

/* File: sim/shp_handler_port_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module shp_handler_port_test;
  logic clock = 0, rst_n = 0, key_lock_n = 1, pin_trigger_mode = 0, list_mode = 0, go = 0;
  logic aux_enable = 0, soft_trigger = 0, analog_done_evt = 0, result_evt = 0, contact_open = 0;
  logic [23:0]  primary_val = '0, secondary_val = '0, sec_hi = 24'h14, sec_lo = 24'h0a;
  logic [215:0] bin_hi, bin_lo;
  logic [9:0]   list_fail = '0;
  logic [7:0]   key_press = '0, key_accept_q;
  logic         trigger_in_line, analog_done_n_q, measurement_complete_n_q, contact_alarm_n_q, meas_start_q, busy_q;
  shp_pkg::shp_sort_t sort_n_q;
  int           num_errors = 0, num_checks = 0;
  // 200 MHz clock
  always #2.5 clock = ~clock;
  shp_handler_port u_shp_handler_port (.clock, .rst_n, .trigger_in_line, .key_lock_n, .sort_n_q, .analog_done_n_q,
    .measurement_complete_n_q, .contact_alarm_n_q, .pin_trigger_mode, .list_mode, .aux_enable, .soft_trigger,
    .analog_done_evt, .result_evt, .contact_open, .primary_val, .secondary_val, .bin_hi, .bin_lo, .sec_hi, .sec_lo,
    .list_fail, .meas_start_q, .busy_q, .key_press, .key_accept_q);
  shp_handler_model u_shp_handler_model (.clock, .go, .trigger_in_line);
  // inputs set by the tasks move 1 ns after the edge so no race with the design's sampling
  task automatic step(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic exp(logic [8:0] c, logic r, a, h, l, s);
    `CHK(sort_n_q, shp_pkg::shp_sort_t'({c, r, a, h, l, s}))
  endtask : exp
  // engine side after an accepted start: fixed latencies from the hand-over
  task automatic engine;
    analog_done_evt = 1;
    step();
    analog_done_evt = 0;
    `CHK(analog_done_n_q, 1'b0)
    `CHK(measurement_complete_n_q, 1'b1)
    result_evt = 1;
    step();
    result_evt = 0;
    step();
    `CHK(measurement_complete_n_q, 1'b0)
    `CHK(busy_q, 1'b0)
  endtask : engine
  task automatic meas(logic [23:0] p, s);
    primary_val = p;
    secondary_val = s;
    soft_trigger = 1;
    step();
    soft_trigger = 0;
    `CHK(meas_start_q, 1'b1)
    `CHK(busy_q, 1'b1)
    engine();
  endtask : meas
  task automatic t_bins;
    for (int k = 0; k < 9; k++) begin
      meas(24'(100 * k + 100), 24'h0a);
      exp(~(9'h1 << k), 1, 1, 1, 1, 1);
    end
  endtask : t_bins
  task automatic t_flags;
    meas(24'h3e8, 24'h14);
    exp(9'h1ff, 0, 1, 0, 1, 1);
    meas(24'h63, 24'h14);
    exp(9'h1ff, 0, 1, 1, 0, 1);
  endtask : t_flags
  task automatic t_sfail;
    meas(24'h96, 24'h15);
    exp(9'h1ff, 0, 1, 1, 1, 0);
    aux_enable = 1;
    meas(24'h96, 24'h09);
    exp(9'h1ff, 1, 0, 1, 1, 0);
  endtask : t_sfail
  // a soft request is ignored in pin mode; the pin start keeps the old result
  task automatic t_pin;
    pin_trigger_mode = 1;
    soft_trigger = 1;
    step();
    soft_trigger = 0;
    step(2);
    `CHK(meas_start_q, 1'b0)
    go = 1;
    step();
    go = 0;
    for (int i = 0; i < 8 && !meas_start_q; i++) step();
    `CHK(meas_start_q, 1'b1)
    `CHK(measurement_complete_n_q, 1'b1)
    exp(9'h1ff, 1, 0, 1, 1, 0);
    engine();
    step(220);
    pin_trigger_mode = 0;
  endtask : t_pin
  task automatic t_lock;
    key_lock_n = 0;
    step(6);
    key_press = 8'ha5;
    step();
    `CHK(key_accept_q, 8'h00)
    key_lock_n = 1;
    step(7);
    `CHK(key_accept_q, 8'ha5)
    key_press = 8'h00;
  endtask : t_lock
  task automatic t_alarm;
    contact_open = 1;
    step();
    `CHK(contact_alarm_n_q, 1'b0)
    contact_open = 0;
    step();
    `CHK(contact_alarm_n_q, 1'b1)
  endtask : t_alarm
  task automatic t_list;
    list_mode = 1;
    list_fail = 10'h201;
    meas(24'h96, 24'h0f);
    exp(9'h1fe, 0, 0, 1, 1, 0);
  endtask : t_list
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // bins are contiguous windows of 100 counts starting at 100
  initial begin
    for (int k = 0; k < 9; k++) begin
      bin_lo[k*24 +: 24] = 24'(100 * k + 100);
      bin_hi[k*24 +: 24] = 24'(100 * k + 199);
    end
    step(5);
    rst_n = 1;
    t_bins();
    t_flags();
    t_sfail();
    t_pin();
    t_lock();
    t_alarm();
    t_list();
    summarize();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #50000;
    num_errors++;
    summarize();
  end
endmodule : shp_handler_port_test
bind shp_handler_port shp_handler_port_properties #(.NKEYS(NKEYS)) u_props (.clock, .rst_n, .trigger_in_line,
  .key_lock_n, .pin_trigger_mode, .list_mode, .analog_done_evt, .result_evt, .contact_open, .key_press, .sort_n_q,
  .analog_done_n_q, .measurement_complete_n_q, .contact_alarm_n_q, .meas_start_q, .key_accept_q);
